// file: flash_cmd_defines.vh
// Opcode, count and field constants for the flash command decoder.
// Assumes inclusion by bare name from the decoder source.
`ifndef FLASH_CMD_DEFINES_VH
`define FLASH_CMD_DEFINES_VH

// ****************************************
// Opcodes
// ****************************************
`define OP_IDLE          8'h00
`define OP_LATCH_SET     8'h06
`define OP_LATCH_CLEAR   8'h04
`define OP_STATUS_READ   8'h05
`define OP_STATUS_WRITE  8'h01
`define OP_PAGE_WRITE    8'h02
`define OP_QPAGE_WRITE   8'h38
`define OP_SECTOR_WIPE   8'h20
`define OP_HALF_WIPE     8'h52
`define OP_BLOCK_WIPE    8'hD8
`define OP_CHIP_WIPE_A   8'h60
`define OP_CHIP_WIPE_B   8'hC7
`define OP_SUSPEND       8'hB0
`define OP_RESUME        8'h30
`define OP_IDENT_READ    8'h9F
`define OP_MAKER_PART    8'h90
`define OP_LOCK_QUERY    8'h3C
`define OP_RESET_ARM     8'h66
`define OP_RESET_MEM     8'h99
`define OP_QUAD_ENTRY    8'h35
`define OP_QUAD_EXIT     8'hF5
`define OP_SINGLE_LOCK   8'h36
`define OP_SINGLE_UNLOCK 8'h39
`define OP_GANG_LOCK     8'h7E
`define OP_GANG_UNLOCK   8'h98
`define OP_DEEP_DOWN     8'hB9
`define OP_RELEASE_DOWN  8'hAB
`define OP_BURST_LEN     8'hC0
`define OP_PROT_SELECT   8'h68
`define OP_QUAD_ID       8'hAF
`define OP_SEC_ENTER     8'hB1
`define OP_SEC_EXIT      8'hC1
`define OP_SEC_READ      8'h2B
`define OP_SEC_WRITE     8'h2F

// ****************************************
// Counts and field values
// ****************************************
`define OPC_BITS         4'h8
`define ADDR_BITS        5'h18
`define BIT_CNT_W        5
`define ID_SEL_DEVICE    8'h01

`endif

// file: flash_cmd_decode.v
// Command decoder and write enable latch of a serial NOR flash.
// Assumes chip select, serial clock and data lines come from pins in
// another domain; op_done_i and busy_i come from logic on ref_clk_i.
// Notes on behaviour
// - Opcode 35h enters four-wire command mode
// - Opcode F5h returns to single-line mode
// - Lock query takes three address bytes
// - Quad mode rejects 35h, 90h, 9Fh, AFh, 03h, BBh, E7h and 5Ah
// - Quad I/O counts nibbles, MSB on line3
// - ID query address selects maker or part
// - Reset-memory only directly after reset-arm
// - Latch-set command sets write enable latch
// - Opcode 8 clocks single, 2 quad
// - Latch-clear command clears write enable latch
// - Completion, suspend and power-up clear latch
// - Writes rejected while latch clear
// - Ident read ignored while busy
`include "flash_cmd_defines.vh"
`default_nettype none

module flash_cmd_decode (
   input wire ref_clk_i,
   input wire rst_b_i,
   input wire cs_b_i,
   input wire sclk_i,
   input wire input_data_line_i,
   input wire [2:0] upper_data_lines_i,
   input wire busy_i,
   input wire op_done_i,
   input wire suspend_done_i,
   output reg four_wire_cmd_mode_o,
   output reg write_enable_latch_o,
   output reg [7:0] opcode_o,
   output reg opcode_valid_o,
   output reg write_go_o,
   output reg ident_read_o,
   output reg maker_part_o,
   output reg maker_first_o,
   output reg lock_query_o,
   output reg [23:0] query_addr_o,
   output reg reset_mem_o
);

   // ****************************************
   // Pin synchronisers
   // ****************************************
   reg [5:0] pin_a_ff;
   reg [5:0] pin_b_ff;
   reg sclk_prev_ff;
   always @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         // Serial clock starts at its idle low level so no false edge follows reset
         pin_a_ff <= 6'h2f;
         pin_b_ff <= 6'h2f;
         sclk_prev_ff <= 1'b0;
      end else begin
         pin_a_ff <= {cs_b_i, sclk_i, upper_data_lines_i, input_data_line_i};
         pin_b_ff <= pin_a_ff;
         sclk_prev_ff <= pin_b_ff[4];
      end
   end
   wire cs_b = pin_b_ff[5];
   wire sclk_rise = pin_b_ff[4] & ~sclk_prev_ff;
   wire [3:0] lines = pin_b_ff[3:0];

   // ****************************************
   // Shift and phase tracking
   // ****************************************
   localparam PH_OPC = 2'h0;
   localparam PH_ADDR = 2'h1;
   localparam PH_DONE = 2'h2;

   reg [1:0] phase_ff;
   reg [`BIT_CNT_W-1:0] cnt_ff;
   reg [23:0] shift_ff;
   reg [7:0] cmd_ff;
   reg armed_ff;
   reg [1:0] nxt_phase;
   reg [`BIT_CNT_W-1:0] nxt_cnt;
   reg [23:0] nxt_shift;

   // Single mode ignores upper lines; quad takes a nibble per edge
   wire [`BIT_CNT_W-1:0] step = four_wire_cmd_mode_o ? 5'h04 : 5'h01;
   wire [23:0] shifted = four_wire_cmd_mode_o ? {shift_ff[19:0], lines}
                                              : {shift_ff[22:0], lines[0]};
   wire [`BIT_CNT_W-1:0] cnt_sum = cnt_ff + step;
   wire opc_end = (phase_ff == PH_OPC) && sclk_rise && (cnt_sum == {1'b0, `OPC_BITS});
   wire addr_end = (phase_ff == PH_ADDR) && sclk_rise && (cnt_sum == `ADDR_BITS);
   wire [7:0] opc = shifted[7:0];

   // Commands accepted in quad mode
   // Security entry, exit, read and write stay legal in quad mode
   function dual_ok;
      input [7:0] c;
      begin
         case (c)
            `OP_QUAD_ENTRY: dual_ok = 1'b0;
            `OP_MAKER_PART: dual_ok = 1'b0;
            `OP_IDENT_READ: dual_ok = 1'b0;
            `OP_QUAD_ID: dual_ok = 1'b0;
            8'h03: dual_ok = 1'b0;
            8'hBB: dual_ok = 1'b0;
            8'hE7: dual_ok = 1'b0;
            8'h5A: dual_ok = 1'b0;
            default: dual_ok = 1'b1;
         endcase
      end
   endfunction

   function is_write;
      input [7:0] c;
      begin
         case (c)
            `OP_STATUS_WRITE, `OP_PAGE_WRITE, `OP_QPAGE_WRITE, `OP_SECTOR_WIPE,
            `OP_HALF_WIPE, `OP_BLOCK_WIPE, `OP_CHIP_WIPE_A,
            `OP_CHIP_WIPE_B: is_write = 1'b1;
            default: is_write = 1'b0;
         endcase
      end
   endfunction

   wire opc_ok = ~four_wire_cmd_mode_o | dual_ok(opc);
   wire needs_addr = (opc == `OP_LOCK_QUERY) || (opc == `OP_MAKER_PART);

   always @* begin
      nxt_phase = phase_ff;
      nxt_cnt = cnt_ff;
      nxt_shift = shift_ff;
      if (cs_b) begin
         // Partial commands are dropped at chip select rise
         nxt_phase = PH_OPC;
         nxt_cnt = {`BIT_CNT_W{1'b0}};
         nxt_shift = 24'h00_0000;
      end else if (sclk_rise && phase_ff != PH_DONE) begin
         nxt_shift = shifted;
         nxt_cnt = cnt_sum;
         if (opc_end) begin
            nxt_cnt = {`BIT_CNT_W{1'b0}};
            nxt_phase = (opc_ok && needs_addr) ? PH_ADDR : PH_DONE;
         end else if (addr_end) begin
            nxt_phase = PH_DONE;
         end
      end
   end

   // ****************************************
   // Command effects
   // ****************************************
   wire take = opc_end && opc_ok;
   always @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         phase_ff <= PH_OPC;
         cnt_ff <= {`BIT_CNT_W{1'b0}};
         shift_ff <= 24'h00_0000;
         cmd_ff <= `OP_IDLE;
         armed_ff <= 1'b0;
         four_wire_cmd_mode_o <= 1'b0;
         write_enable_latch_o <= 1'b0;
         opcode_o <= `OP_IDLE;
         opcode_valid_o <= 1'b0;
         write_go_o <= 1'b0;
         ident_read_o <= 1'b0;
         maker_part_o <= 1'b0;
         maker_first_o <= 1'b0;
         lock_query_o <= 1'b0;
         query_addr_o <= 24'h00_0000;
         reset_mem_o <= 1'b0;
      end else begin
         phase_ff <= nxt_phase;
         cnt_ff <= nxt_cnt;
         shift_ff <= nxt_shift;
         opcode_valid_o <= take;
         write_go_o <= 1'b0;
         ident_read_o <= 1'b0;
         maker_part_o <= 1'b0;
         lock_query_o <= 1'b0;
         reset_mem_o <= 1'b0;
         if (take) begin
            opcode_o <= opc;
            cmd_ff <= opc;
            // Any accepted command other than reset-arm disarms
            armed_ff <= (opc == `OP_RESET_ARM);
            case (opc)
               `OP_QUAD_ENTRY: four_wire_cmd_mode_o <= 1'b1;
               `OP_QUAD_EXIT: four_wire_cmd_mode_o <= 1'b0;
               `OP_LATCH_SET: write_enable_latch_o <= 1'b1;
               `OP_LATCH_CLEAR: write_enable_latch_o <= 1'b0;
               `OP_RESET_MEM: begin
                  reset_mem_o <= armed_ff;
                  if (armed_ff) begin
                     four_wire_cmd_mode_o <= 1'b0;
                     write_enable_latch_o <= 1'b0;
                  end
               end
               `OP_IDENT_READ: ident_read_o <= ~busy_i;
               `OP_IDLE: ;
               default: write_go_o <= is_write(opc) & write_enable_latch_o;
            endcase
         end
         if (addr_end) begin
            query_addr_o <= shifted;
            if (cmd_ff == `OP_LOCK_QUERY)
               lock_query_o <= 1'b1;
            else begin
               maker_part_o <= 1'b1;
               // Only a low byte of 01h picks the order; other values act as 00h
               maker_first_o <= (shifted[7:0] != `ID_SEL_DEVICE);
            end
         end
         // Completion clear placed last so it wins over a same-cycle set
         if (op_done_i || suspend_done_i)
            write_enable_latch_o <= 1'b0;
      end
   end

endmodule

`default_nettype wire

// file: flash_cmd_decode_monitor.sv
// Port checker for the flash command decoder.
// Assumes it is bound onto flash_cmd_decode; all ports but cs_b_i on ref_clk_i.
`include "flash_cmd_defines.vh"
`default_nettype none
module flash_cmd_decode_monitor (
   input wire ref_clk_i,
   input wire rst_b_i,
   input wire cs_b_i,
   input wire busy_i,
   input wire op_done_i,
   input wire suspend_done_i,
   input wire four_wire_cmd_mode_o,
   input wire write_enable_latch_o,
   input wire [7:0] opcode_o,
   input wire opcode_valid_o,
   input wire write_go_o,
   input wire ident_read_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!rst_b_i);
   a_ident_not_busy: assert property (ident_read_o |-> !$past(busy_i))
      else $error("ident read while busy");
   a_go_needs_latch: assert property (write_go_o |-> $past(write_enable_latch_o))
      else $error("write accepted with latch clear");
   a_done_clears: assert property (op_done_i |=> !write_enable_latch_o)
      else $error("latch kept after completion");
   a_susp_clears: assert property (suspend_done_i |=> !write_enable_latch_o)
      else $error("latch kept after suspend");
   a_valid_pulse: assert property (opcode_valid_o |=> !opcode_valid_o)
      else $error("opcode valid longer than one cycle");
   a_cs_quiet: assert property (cs_b_i [*8] |-> !opcode_valid_o)
      else $error("opcode accepted while deselected");
   a_latch_rise: assert property ($rose(write_enable_latch_o) |->
      opcode_valid_o && opcode_o == `OP_LATCH_SET)
      else $error("latch set without set command");
   a_mode_rise: assert property ($rose(four_wire_cmd_mode_o) |->
      opcode_valid_o && opcode_o == `OP_QUAD_ENTRY)
      else $error("quad mode without entry command");
endmodule
bind flash_cmd_decode flash_cmd_decode_monitor i_mon (.ref_clk_i(ref_clk_i),
   .rst_b_i(rst_b_i), .cs_b_i(cs_b_i), .busy_i(busy_i), .op_done_i(op_done_i),
   .suspend_done_i(suspend_done_i), .four_wire_cmd_mode_o(four_wire_cmd_mode_o),
   .write_enable_latch_o(write_enable_latch_o), .opcode_o(opcode_o),
   .opcode_valid_o(opcode_valid_o), .write_go_o(write_go_o), .ident_read_o(ident_read_o));
`default_nettype wire

// file: flash_host_model.sv
// Host serial controller model driving chip select, clock and data.
// Assumes the bench calls frame(); link clock 320 ns, idle low.
`default_nettype none
module flash_host_model (
   output logic cs_b_o,
   output logic sclk_o,
   output logic [3:0] dq_o
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      cs_b_o = 1'b1;
      sclk_o = 1'b0;
      dq_o = 4'h0;
   end
   // MSB first, 1 or 4 bits an edge; short n raises select early
   task automatic frame(input logic [31:0] bits, input int n, input logic quad);
      #7 cs_b_o = 1'b0;
      for (int i = 0; i < n; i++) begin
         // Unused lines toggle in single mode to expose any use
         dq_o = quad ? bits[31:28] : {~{3{bits[31]}}, bits[31]};
         bits = quad ? bits << 4 : bits << 1;
         #160 sclk_o = 1'b1;
         #160 sclk_o = 1'b0;
      end
      #160 cs_b_o = 1'b1;
      dq_o = ~dq_o;
      #640;
   endtask
endmodule
`default_nettype wire

// file: flash_cmd_decode_tb.sv
// Self-checking bench for the flash command decoder.
// Assumes the host model drives pins; the bench drives the clock side.
`include "flash_cmd_defines.vh"
`default_nettype none
module flash_cmd_decode_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk = 1'b0, rst_b = 1'b0, busy = 1'b0, done = 1'b0, susp = 1'b0, clr = 1'b0;
   logic cs_b, sclk;
   logic [3:0] dq;
   wire mode, write_enable_latch, ov, go, idr, mp, mf, lq, rm;
   wire [7:0] opc;
   wire [23:0] qa;
   logic [5:0] seen = 6'h00, m = 6'h3F;
   int mismatches = 0, checks_done = 0;
   flash_host_model i_host (.cs_b_o(cs_b), .sclk_o(sclk), .dq_o(dq));
   flash_cmd_decode i_dut (.ref_clk_i(ref_clk), .rst_b_i(rst_b), .cs_b_i(cs_b), .sclk_i(sclk),
      .input_data_line_i(dq[0]), .upper_data_lines_i(dq[3:1]), .busy_i(busy), .op_done_i(done),
      .suspend_done_i(susp), .four_wire_cmd_mode_o(mode), .write_enable_latch_o(write_enable_latch),
      .opcode_o(opc), .opcode_valid_o(ov), .write_go_o(go), .ident_read_o(idr),
      .maker_part_o(mp), .maker_first_o(mf), .lock_query_o(lq), .query_addr_o(qa),
      .reset_mem_o(rm));
   initial forever #20 ref_clk = ~ref_clk;
   always @(posedge ref_clk) seen <= clr ? 6'h00 : seen | {rm, lq, mp, idr, go, ov};
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cmd(input logic [31:0] b, input int n, input logic q, input logic [5:0] e);
      @(negedge ref_clk) clr = 1'b1;
      @(negedge ref_clk) clr = 1'b0;
      i_host.frame(b, n, q);
      chk(seen & m, e & m);
   endtask
   task automatic pulse(input logic s);
      @(negedge ref_clk) {susp, done} = {s, !s};
      @(negedge ref_clk) {susp, done} = 2'b00;
      @(negedge ref_clk);
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      #1_000_000;
      mismatches++;
      end_of_test();
   end
   initial begin
      repeat (20) @(negedge ref_clk);
      rst_b = 1'b1;
      repeat (3) @(negedge ref_clk);
      chk({mode, write_enable_latch}, 2'b00);
      cmd({`OP_PAGE_WRITE, 24'h00_0000}, 32, 0, 6'h01);
      cmd({`OP_LATCH_SET, 24'h00_0000}, 8, 0, 6'h01);
      chk({opc, write_enable_latch}, {`OP_LATCH_SET, 1'b1});
      cmd({`OP_PAGE_WRITE, 24'h00_0000}, 32, 0, 6'h03);
      pulse(0);
      chk(write_enable_latch, 1'b0);
      cmd({`OP_LATCH_SET, 24'h00_0000}, 8, 0, 6'h01);
      pulse(1);
      chk(write_enable_latch, 1'b0);
      cmd({`OP_LATCH_SET, 24'h00_0000}, 8, 0, 6'h01);
      cmd({`OP_LATCH_CLEAR, 24'h00_0000}, 8, 0, 6'h01);
      chk(write_enable_latch, 1'b0);
      busy = 1'b1;
      m = 6'h04;
      cmd({`OP_IDENT_READ, 24'h00_0000}, 8, 0, 6'h00);
      busy = 1'b0;
      m = 6'h3F;
      cmd({`OP_IDENT_READ, 24'h00_0000}, 8, 0, 6'h05);
      cmd({`OP_MAKER_PART, 24'h00_0001}, 32, 0, 6'h09);
      chk(mf, 1'b0);
      cmd({`OP_MAKER_PART, 24'h00_0000}, 32, 0, 6'h09);
      chk(mf, 1'b1);
      cmd({`OP_LOCK_QUERY, 24'h12_3456}, 32, 0, 6'h11);
      chk(qa, 24'h12_3456);
      cmd({`OP_RESET_ARM, 24'h00_0000}, 8, 0, 6'h01);
      cmd({`OP_RESET_MEM, 24'h00_0000}, 8, 0, 6'h21);
      cmd({`OP_RESET_ARM, 24'h00_0000}, 8, 0, 6'h01);
      cmd({`OP_IDLE, 24'h00_0000}, 8, 0, 6'h01);
      m = 6'h20;
      cmd({`OP_RESET_MEM, 24'h00_0000}, 8, 0, 6'h00);
      m = 6'h3F;
      cmd({`OP_LATCH_SET, 24'h00_0000}, 4, 0, 6'h00);
      chk(write_enable_latch, 1'b0);
      cmd({`OP_QUAD_ENTRY, 24'h00_0000}, 8, 0, 6'h01);
      chk(mode, 1'b1);
      cmd({`OP_LATCH_SET, 24'h00_0000}, 2, 1, 6'h01);
      chk(write_enable_latch, 1'b1);
      cmd({`OP_IDENT_READ, 24'h00_0000}, 2, 1, 6'h00);
      cmd({`OP_SEC_ENTER, 24'h00_0000}, 2, 1, 6'h01);
      chk(opc, `OP_SEC_ENTER);
      cmd({`OP_QUAD_EXIT, 24'h00_0000}, 2, 1, 6'h01);
      chk(mode, 1'b0);
      end_of_test();
   end
endmodule
`default_nettype wire
